// [core/bridge_power_regs.vh]
`ifndef BRIDGE_POWER_REGS_VH
`define BRIDGE_POWER_REGS_VH
// register byte offsets
`define REG_CTRL          8'h00
`define REG_DRIVE         8'h04
`define REG_RECOVERY      8'h08
`define REG_OVERCURRENT   8'h0C
`define REG_OPEN_LOAD     8'h10
`define REG_ALERT         8'h14
`define REG_BRIDGE_STATUS 8'h18
`define REG_WATCHDOG      8'h1C
// control register fields
`define CTRL_BRIDGE_EN    0
`define CTRL_DECAY_SIDE   1
`define CTRL_DECAY_SINGLE 2
`define CTRL_MON_EN       3
`define CTRL_REC_FREQ_LO  4
`define CTRL_REC_FREQ_HI  5
`define CTRL_MON_SEL_LO   8
`define CTRL_MON_SEL_HI   11
// drive codes, two bits per half-bridge
`define DRIVE_OFF         2'h0
`define DRIVE_HIGH_SIDE   2'h1
`define DRIVE_LOW_SIDE    2'h2
// gate output codes
`define GATE_RESISTIVE    2'h0
`define GATE_LOW          2'h1
`define GATE_HIGH         2'h2
// reset values
`define CTRL_RESET        32'h00000000
// axi responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
// timing
`define CLK_PERIOD_NS     8
`define SINK_TIME_NS      32000
`endif

// [core/bridge_power_ctrl.v]
// How it works
// - active output undercurrent past filter sets open-load
// - overcurrent past filter sets flag, output off
// - without recovery, off until flag cleared
// - source select routes one output to monitor
// - monitor blanked after high-side switch-on, then enabled
// - monitor high impedance while selected output off
// - monitor enable cleared disables current monitor
// - opposite driver waits cross-current time after turn-off
// - on expiry fast turn-off, opposite turns on
// - recovery enabled restarts output after recovery time
// - recovery repetition follows frequency setting
// - alert set on entering auto-recovery
// - recovery cleared, persisting overload switches off
// - disabled, pump-low, thermal: resistive; overvoltage: low
// - drain-source short turns off only that leg
// - pwm high drives diagonal set by direction
// - pwm low, low-side decay per single select
// - pwm low, high-side decay per single select
// - unconnected direction and pwm read low
// - long-open window forces bridge off until trigger
// - failure resistive entry sinks first 32 us
`include "bridge_power_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module bridge_power_ctrl #(
  parameter NOUT         = 4,
  parameter CNT_W        = 16,
  parameter OL_FILT_CYC  = 16,
  parameter OC_FILT_CYC  = 8,
  parameter BLANK_CYC    = 32,
  parameter CCP_CYC      = 16,
  parameter REC_BASE_CYC = 256
) (
  input  wire              i_clk,
  input  wire              i_rst_n,
  input  wire [7:0]        i_awaddr,
  input  wire              i_awvalid,
  output reg               o_awready,
  input  wire [31:0]       i_wdata,
  input  wire [3:0]        i_wstrb,
  input  wire              i_wvalid,
  output reg               o_wready,
  output reg  [1:0]        o_bresp,
  output reg               o_bvalid,
  input  wire              i_bready,
  input  wire [7:0]        i_araddr,
  input  wire              i_arvalid,
  output reg               o_arready,
  output reg  [31:0]       o_rdata,
  output reg  [1:0]        o_rresp,
  output reg               o_rvalid,
  input  wire              i_rready,
  input  wire [NOUT-1:0]   i_out_undercurrent,
  input  wire [NOUT-1:0]   i_out_overcurrent,
  output reg  [NOUT-1:0]   o_out_high_gate,
  output reg  [NOUT-1:0]   o_out_low_gate,
  output reg  [NOUT-1:0]   o_out_fast_off,
  output reg  [1:0]        o_monitor_source_select,
  output reg               o_current_image_pin_drive,
  input  wire              i_bridge_direction_input,
  input  wire              i_bridge_pwm_input,
  input  wire              i_pump_low_flag,
  input  wire              i_supply_overvoltage_flag,
  input  wire              i_supply_undervoltage_flag,
  input  wire              i_thermal_shutdown_flag,
  input  wire [1:0]        i_drain_source_fault_flag,
  input  wire              i_watchdog_safe_window,
  output reg  [1:0]        o_first_high_gate,
  output reg  [1:0]        o_first_low_gate,
  output reg  [1:0]        o_second_high_gate,
  output reg  [1:0]        o_second_low_gate
);
  localparam SINK_CYC = (`SINK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam PIN_N    = 2 * NOUT + 7;

  // reset release through two flops
  reg rst_meta;
  reg rst_n;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // all pins except i_watchdog_safe_window pass two flops; open pins idle low thanks to the pad pull-down
  wire [PIN_N-1:0] pin_raw = {i_out_undercurrent, i_out_overcurrent,
                              i_bridge_direction_input, i_bridge_pwm_input,
                              i_pump_low_flag, i_supply_overvoltage_flag,
                              i_supply_undervoltage_flag, i_thermal_shutdown_flag,
                              i_drain_source_fault_flag[1]};
  reg [PIN_N-1:0] pin_meta;
  reg [PIN_N-1:0] pin_sync;
  reg [1:0]       ds_meta0;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= {PIN_N{1'b0}};
      pin_sync <= {PIN_N{1'b0}};
      ds_meta0 <= 2'h0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      ds_meta0 <= {ds_meta0[0], i_drain_source_fault_flag[0]};
    end
  end
  wire [NOUT-1:0] under_s = pin_sync[PIN_N-1 -: NOUT];
  wire [NOUT-1:0] over_s  = pin_sync[NOUT+6 -: NOUT];
  wire            dir_s   = pin_sync[6];
  wire            pwm_s   = pin_sync[5];
  wire            pump_s  = pin_sync[4];
  wire            ov_s    = pin_sync[3];
  wire            uv_s    = pin_sync[2];
  wire            tsd_s   = pin_sync[1];
  wire [1:0]      ds_s    = {pin_sync[0], ds_meta0[1]};

  // software registers
  reg [31:0]      ctrl;
  reg [31:0]      drive;
  reg [NOUT-1:0]  recov_en;
  reg [NOUT-1:0]  oc_flag;
  reg [NOUT-1:0]  ol_flag;
  reg [NOUT-1:0]  alert_flag;
  reg             long_open;
  wire            bridge_en   = ctrl[`CTRL_BRIDGE_EN];
  wire            decay_side  = ctrl[`CTRL_DECAY_SIDE];
  wire            decay_one   = ctrl[`CTRL_DECAY_SINGLE];
  wire            mon_en      = ctrl[`CTRL_MON_EN];
  wire [1:0]      rec_freq    = ctrl[`CTRL_REC_FREQ_HI:`CTRL_REC_FREQ_LO];
  wire [3:0]      mon_sel     = ctrl[`CTRL_MON_SEL_HI:`CTRL_MON_SEL_LO];

  // write channel: both address and data taken in the same cycle
  wire wr_go = o_awready & i_awvalid & o_wready & i_wvalid;
  wire rd_go = o_arready & i_arvalid;
  wire [NOUT-1:0] oc_set;
  wire [NOUT-1:0] ol_set;
  wire [NOUT-1:0] alert_set;
  wire [NOUT-1:0] wr_clr;
  wire            wr_hit_oc = wr_go & (i_awaddr == `REG_OVERCURRENT);
  wire            wr_hit_ol = wr_go & (i_awaddr == `REG_OPEN_LOAD);
  wire            wr_hit_al = wr_go & (i_awaddr == `REG_ALERT);
  assign wr_clr = i_wdata[NOUT-1:0];

  // bus handshake and register writes; hardware sets win over clears
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_awready  <= 1'b0;
      o_wready   <= 1'b0;
      o_bvalid   <= 1'b0;
      o_bresp    <= `RESP_OKAY;
      ctrl       <= `CTRL_RESET;
      drive      <= 32'h00000000;
      recov_en   <= {NOUT{1'b0}};
      oc_flag    <= {NOUT{1'b0}};
      ol_flag    <= {NOUT{1'b0}};
      alert_flag <= {NOUT{1'b0}};
      long_open  <= 1'b1;
    end else begin
      o_awready <= i_awvalid & i_wvalid & ~o_awready & ~o_bvalid;
      o_wready  <= i_awvalid & i_wvalid & ~o_awready & ~o_bvalid;
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp  <= `RESP_OKAY;
        if (i_awaddr == `REG_CTRL) begin
          if (i_wstrb[0]) ctrl[7:0]  <= i_wdata[7:0];
          if (i_wstrb[1]) ctrl[15:8] <= i_wdata[15:8];
        end else if (i_awaddr == `REG_DRIVE) begin
          if (i_wstrb[0]) drive[7:0] <= i_wdata[7:0];
          if (i_wstrb[1]) drive[15:8] <= i_wdata[15:8];
        end else if (i_awaddr == `REG_RECOVERY) begin
          recov_en <= i_wdata[NOUT-1:0];
        end else if (i_awaddr == `REG_WATCHDOG) begin
          if (!i_wdata[0] && i_watchdog_safe_window) long_open <= 1'b0;
        end else if (!wr_hit_oc && !wr_hit_ol && !wr_hit_al) begin
          o_bresp <= `RESP_SLVERR;
        end
      end
      oc_flag    <= oc_set | (oc_flag & ~(wr_hit_oc ? wr_clr : {NOUT{1'b0}}));
      ol_flag    <= ol_set | (ol_flag & ~(wr_hit_ol ? wr_clr : {NOUT{1'b0}}));
      alert_flag <= alert_set | (alert_flag & ~(wr_hit_al ? wr_clr : {NOUT{1'b0}}));
    end
  end

  // read channel, one transfer at a time
  reg [31:0] rd_word;
  reg        rd_ok;
  always @* begin
    rd_word = 32'h00000000;
    rd_ok   = 1'b1;
    if (i_araddr == `REG_CTRL) begin
      rd_word = {16'h0000, ctrl[15:0]};
    end else if (i_araddr == `REG_DRIVE) begin
      rd_word = {16'h0000, drive[15:0]};
    end else if (i_araddr == `REG_RECOVERY) begin
      rd_word[NOUT-1:0] = recov_en;
    end else if (i_araddr == `REG_OVERCURRENT) begin
      rd_word[NOUT-1:0] = oc_flag;
    end else if (i_araddr == `REG_OPEN_LOAD) begin
      rd_word[NOUT-1:0] = ol_flag;
    end else if (i_araddr == `REG_ALERT) begin
      rd_word[NOUT-1:0] = alert_flag;
    end else if (i_araddr == `REG_BRIDGE_STATUS) begin
      rd_word[7:0] = {1'b0, long_open, ds_s, tsd_s, uv_s, ov_s, pump_s};
    end else if (i_araddr == `REG_WATCHDOG) begin
      rd_word[1] = long_open;
    end else begin
      rd_ok = 1'b0;
    end
  end
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= `RESP_OKAY;
    end else begin
      o_arready <= i_arvalid & ~o_arready & ~o_rvalid;
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
      if (rd_go) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_word;
        o_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // per half-bridge: protection, recovery and cross-current delay
  wire [CNT_W-1:0] rec_time = REC_BASE_CYC[CNT_W-1:0] << rec_freq;
  genvar g;
  generate
    for (g = 0; g < NOUT; g = g + 1) begin : g_out
      reg              tripped;
      reg [CNT_W-1:0]  oc_cnt;
      reg [CNT_W-1:0]  ol_cnt;
      reg [CNT_W-1:0]  rec_cnt;
      reg [CNT_W-1:0]  dead_cnt;
      wire [1:0] mode    = drive[2*g+1:2*g];
      wire       is_on   = o_out_high_gate[g] | o_out_low_gate[g];
      wire       want_hs = (mode == `DRIVE_HIGH_SIDE) & ~tripped;
      wire       want_ls = (mode == `DRIVE_LOW_SIDE) & ~tripped;
      wire       oc_hit  = is_on & over_s[g] & (oc_cnt == OC_FILT_CYC[CNT_W-1:0]);
      assign oc_set[g]    = oc_hit;
      assign ol_set[g]    = is_on & under_s[g] & (ol_cnt == OL_FILT_CYC[CNT_W-1:0]);
      assign alert_set[g] = oc_hit & recov_en[g];

      // filters count while the condition holds on an active stage
      always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          oc_cnt <= {CNT_W{1'b0}};
          ol_cnt <= {CNT_W{1'b0}};
        end else begin
          if (!is_on || !over_s[g] || oc_hit) oc_cnt <= {CNT_W{1'b0}};
          else oc_cnt <= oc_cnt + 1'b1;
          if (!is_on || !under_s[g] || ol_set[g]) ol_cnt <= {CNT_W{1'b0}};
          else ol_cnt <= ol_cnt + 1'b1;
        end
      end

      // latched shutdown; recovery retries, otherwise wait for the flag clear
      always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          tripped <= 1'b0;
          rec_cnt <= {CNT_W{1'b0}};
        end else if (oc_hit) begin
          tripped <= 1'b1;
          rec_cnt <= {CNT_W{1'b0}};
        end else if (tripped && recov_en[g]) begin
          rec_cnt <= rec_cnt + 1'b1;
          if (rec_cnt + 1'b1 >= rec_time) tripped <= 1'b0;
        end else if (tripped && !oc_flag[g]) begin
          tripped <= 1'b0;
        end
      end

      // turn off first, hold the dead time, then fast off and turn on
      always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          o_out_high_gate[g] <= 1'b0;
          o_out_low_gate[g]  <= 1'b0;
          o_out_fast_off[g]  <= 1'b0;
          dead_cnt           <= {CNT_W{1'b0}};
        end else if ((o_out_high_gate[g] && !want_hs) || (o_out_low_gate[g] && !want_ls)) begin
          o_out_high_gate[g] <= o_out_high_gate[g] & want_hs;
          o_out_low_gate[g]  <= o_out_low_gate[g] & want_ls;
          o_out_fast_off[g]  <= 1'b0;
          dead_cnt           <= CCP_CYC[CNT_W-1:0];
        end else if (dead_cnt != {CNT_W{1'b0}}) begin
          dead_cnt <= dead_cnt - 1'b1;
          if (dead_cnt == {{(CNT_W-1){1'b0}}, 1'b1}) o_out_fast_off[g] <= 1'b1;
        end else begin
          o_out_high_gate[g] <= want_hs;
          o_out_low_gate[g]  <= want_ls;
        end
      end
    end
  endgenerate

  // current monitor: mux, blanking and high impedance
  reg [CNT_W-1:0] blank_cnt;
  wire            sel_on = o_out_high_gate[mon_sel[1:0]];
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_cnt                 <= {CNT_W{1'b0}};
      o_monitor_source_select   <= 2'h0;
      o_current_image_pin_drive <= 1'b0;
    end else begin
      o_monitor_source_select <= mon_sel[1:0];
      if (!mon_en || !sel_on || mon_sel[1:0] != o_monitor_source_select) begin
        blank_cnt                 <= {CNT_W{1'b0}};
        o_current_image_pin_drive <= 1'b0;
      end else if (blank_cnt != BLANK_CYC[CNT_W-1:0]) begin
        blank_cnt <= blank_cnt + 1'b1;
      end else begin
        o_current_image_pin_drive <= 1'b1;
      end
    end
  end

  // bridge truth table; disable and faults are looked at first
  reg [7:0] next_gates;
  reg       next_fail_rl;
  reg [1:0] leg1;
  reg [1:0] leg2;
  always @* begin
    next_fail_rl = 1'b0;
    leg1 = {`GATE_LOW};
    leg2 = {`GATE_LOW};
    next_gates = {4{`GATE_RESISTIVE}};
    if (!bridge_en) begin
      next_gates = {4{`GATE_RESISTIVE}};
    end else if (pump_s || tsd_s) begin
      next_gates   = {4{`GATE_RESISTIVE}};
      next_fail_rl = 1'b1;
    end else if (ov_s || uv_s || long_open) begin
      next_gates = {4{`GATE_LOW}};
    end else begin
      // order in next_gates: first high, first low, second high, second low
      if (pwm_s) begin
        next_gates = dir_s ? {`GATE_HIGH, `GATE_LOW, `GATE_LOW, `GATE_HIGH}
                           : {`GATE_LOW, `GATE_HIGH, `GATE_HIGH, `GATE_LOW};
      end else if (!decay_side) begin
        if (!decay_one)
          next_gates = {`GATE_LOW, `GATE_HIGH, `GATE_LOW, `GATE_HIGH};
        else if (!dir_s)
          next_gates = {`GATE_LOW, `GATE_HIGH, `GATE_LOW, `GATE_LOW};
        else
          next_gates = {`GATE_LOW, `GATE_LOW, `GATE_LOW, `GATE_HIGH};
      end else begin
        if (!decay_one)
          next_gates = {`GATE_HIGH, `GATE_LOW, `GATE_HIGH, `GATE_LOW};
        else if (!dir_s)
          next_gates = {`GATE_LOW, `GATE_LOW, `GATE_HIGH, `GATE_LOW};
        else
          next_gates = {`GATE_HIGH, `GATE_LOW, `GATE_LOW, `GATE_LOW};
      end
      if (ds_s[0]) next_gates[7:4] = {leg1, leg1};
      if (ds_s[1]) next_gates[3:0] = {leg2, leg2};
    end
  end

  // failure entry into resistive low sinks hard first
  reg        fail_rl_q;
  reg [12:0] sink_cnt;
  wire       sink_start = next_fail_rl & ~fail_rl_q;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_rl_q          <= 1'b0;
      sink_cnt           <= 13'h0000;
      o_first_high_gate  <= `GATE_RESISTIVE;
      o_first_low_gate   <= `GATE_RESISTIVE;
      o_second_high_gate <= `GATE_RESISTIVE;
      o_second_low_gate  <= `GATE_RESISTIVE;
    end else begin
      fail_rl_q <= next_fail_rl;
      if (sink_start) sink_cnt <= SINK_CYC[12:0];
      else if (!next_fail_rl) sink_cnt <= 13'h0000;
      else if (sink_cnt != 13'h0000) sink_cnt <= sink_cnt - 1'b1;
      if (sink_start || (next_fail_rl && sink_cnt > 13'h0001)) begin
        o_first_high_gate  <= `GATE_LOW;
        o_first_low_gate   <= `GATE_LOW;
        o_second_high_gate <= `GATE_LOW;
        o_second_low_gate  <= `GATE_LOW;
      end else begin
        o_first_high_gate  <= next_gates[7:6];
        o_first_low_gate   <= next_gates[5:4];
        o_second_high_gate <= next_gates[3:2];
        o_second_low_gate  <= next_gates[1:0];
      end
    end
  end
endmodule // bridge_power_ctrl
`default_nettype wire

// [testbench/bridge_power_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bridge_power_regs.vh"
module bridge_power_chk #(
  parameter NOUT      = 4,
  parameter BLANK_CYC = 32
) (
  input wire logic            i_clk,
  input wire logic            i_rst_n,
  input wire logic            o_awready,
  input wire logic            o_wready,
  input wire logic            o_bvalid,
  input wire logic            i_bready,
  input wire logic [1:0]      o_bresp,
  input wire logic            o_rvalid,
  input wire logic            i_rready,
  input wire logic [31:0]     o_rdata,
  input wire logic [NOUT-1:0] i_out_overcurrent,
  input wire logic [NOUT-1:0] o_out_high_gate,
  input wire logic [NOUT-1:0] o_out_low_gate,
  input wire logic [NOUT-1:0] o_out_fast_off,
  input wire logic [1:0]      o_monitor_source_select,
  input wire logic            o_current_image_pin_drive,
  input wire logic            i_supply_overvoltage_flag,
  input wire logic [1:0]      o_first_high_gate,
  input wire logic [1:0]      o_first_low_gate,
  input wire logic [1:0]      o_second_high_gate,
  input wire logic [1:0]      o_second_low_gate
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] on_cnt;
  wire        sel_on = o_out_high_gate[o_monitor_source_select];
  wire        out0_on = o_out_high_gate[0] | o_out_low_gate[0];
  wire        any_high = (o_first_high_gate == `GATE_HIGH) | (o_first_low_gate == `GATE_HIGH)
                       | (o_second_high_gate == `GATE_HIGH) | (o_second_low_gate == `GATE_HIGH);
  // on-time of the selected output; saturates so a long run cannot wrap to zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) on_cnt <= 8'h00;
    else if (!sel_on) on_cnt <= 8'h00;
    else if (on_cnt != 8'hFF) on_cnt <= on_cnt + 8'h01;
  end
  // overcurrent seen by conducting output 0 for the whole filter span
  sequence oc_held;
    (out0_on && i_out_overcurrent[0]) [*8];
  endsequence
  sequence stays_off;
    !out0_on [*2];
  endsequence
  wr_ready_pair_a: assert property (o_awready == o_wready)
    else $error("write readies differ");
  wr_resp_next_a: assert property (o_awready |=> o_bvalid)
    else $error("write response late");
  b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  no_shoot_a: assert property ((o_out_high_gate & o_out_low_gate) == '0)
    else $error("both drivers of a half-bridge on");
  dead_time_a: assert property ($fell(o_out_high_gate[0]) |-> !o_out_low_gate[0] [*8])
    else $error("opposite driver on inside dead time");
  fast_off_a: assert property ($rose(o_out_fast_off[0]) |-> !out0_on)
    else $error("fast turn-off while conducting");
  oc_trip_a: assert property (oc_held |-> ##[1:8] stays_off)
    else $error("overcurrent did not switch off");
  mon_blank_a: assert property ($rose(o_current_image_pin_drive) |-> on_cnt >= BLANK_CYC)
    else $error("current image not blanked");
  mon_hiz_a: assert property (!sel_on [*2] |-> !o_current_image_pin_drive)
    else $error("current image driven while off");
  ov_no_high_a: assert property (i_supply_overvoltage_flag [*6] |-> !any_high)
    else $error("gate high under overvoltage");
endmodule // bridge_power_chk
bind bridge_power_ctrl bridge_power_chk #(.NOUT(NOUT), .BLANK_CYC(BLANK_CYC)) chk_u (
  .i_clk, .i_rst_n, .o_awready, .o_wready, .o_bvalid, .i_bready, .o_bresp, .o_rvalid,
  .i_rready, .o_rdata, .i_out_overcurrent, .o_out_high_gate, .o_out_low_gate, .o_out_fast_off,
  .o_monitor_source_select, .o_current_image_pin_drive, .i_supply_overvoltage_flag,
  .o_first_high_gate, .o_first_low_gate, .o_second_high_gate, .o_second_low_gate);
`default_nettype wire

// [testbench/load_model.sv]
`timescale 1ns/1ps
`default_nettype none
module load_model #(
  parameter NOUT = 4
) (
  input  wire logic [NOUT-1:0] i_high_gate,
  input  wire logic [NOUT-1:0] i_low_gate,
  input  wire logic [NOUT-1:0] i_short,
  input  wire logic [NOUT-1:0] i_open,
  output wire logic [NOUT-1:0] o_overcurrent,
  output wire logic [NOUT-1:0] o_undercurrent
);
  // a short loads whichever side conducts, so low-then-high probing finds it
  assign o_overcurrent  = (i_high_gate | i_low_gate) & i_short;
  // an open load shows only while the high side of the stage is driven
  assign o_undercurrent = i_high_gate & i_open;
endmodule // load_model
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bridge_power_regs.vh"
module tb_top;
  localparam int REC = 16;
  logic        i_clk = 1'b0, i_rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid, ci;
  logic [1:0]  bresp, rresp, msel, fh, fl, sh, sl, ds = 2'h0;
  logic [3:0]  hg, lg, fast, oc, uc, short = 4'h0, open = 4'h0;
  logic        dir = 1'b0, pwm = 1'b0, pump = 1'b0, ov = 1'b0, uv = 1'b0, tsd = 1'b0;
  logic        win = 1'b0;
  int          n_errors = 0, compares = 0, n;
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  bridge_power_ctrl #(.REC_BASE_CYC(REC)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_out_undercurrent(uc), .i_out_overcurrent(oc), .o_out_high_gate(hg), .o_out_low_gate(lg),
    .o_out_fast_off(fast), .o_monitor_source_select(msel), .o_current_image_pin_drive(ci),
    .i_bridge_direction_input(dir), .i_bridge_pwm_input(pwm), .i_pump_low_flag(pump),
    .i_supply_overvoltage_flag(ov), .i_supply_undervoltage_flag(uv),
    .i_thermal_shutdown_flag(tsd), .i_drain_source_fault_flag(ds),
    .i_watchdog_safe_window(win), .o_first_high_gate(fh), .o_first_low_gate(fl),
    .o_second_high_gate(sh), .o_second_low_gate(sl));
  load_model ld_u (.i_high_gate(hg), .i_low_gate(lg), .i_short(short), .i_open(open),
    .o_overcurrent(oc), .o_undercurrent(uc));
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string w);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  function automatic logic hs(input int w);
    case (w)
      0: return awready;
      1: return bvalid;
      2: return arready;
      default: return rvalid;
    endcase
  endfunction
  // the slave sets the pace; a wait ends on the handshake or after 200 cycles
  task automatic wait_hi(input int w);
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (hs(w) !== 1'b1 && k < 200);
    if (hs(w) !== 1'b1) begin
      n_errors++;
      $display("BAD t=%0t handshake timeout", $time);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wait_hi(0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wait_hi(1);
    check({30'h0, bresp}, {30'h0, er}, "bresp");
    bready <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wait_hi(2);
    arvalid <= 1'b0;
    wait_hi(3);
    check(rdata, ed, "rdata");
    check({30'h0, rresp}, {30'h0, er}, "rresp");
    rready <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge i_clk);
  endtask
  task automatic gates(input logic [7:0] e);
    check({24'h0, fh, fl, sh, sl}, {24'h0, e}, "gates");
  endtask
  task automatic wait_lg(input logic v, output int c);
    c = 0;
    while (lg[0] !== v && c < 400) begin
      @(posedge i_clk);
      c++;
    end
    if (lg[0] !== v) begin
      n_errors++;
      $display("BAD t=%0t low gate wait timeout", $time);
      tally_and_finish();
    end
  endtask
  // expected gate codes in order first high, first low, second high, second low
  function automatic logic [7:0] tbl(input logic d, input logic p, input logic s, input logic q);
    logic [3:0] h;
    logic [7:0] g;
    if (p) h = d ? 4'b1001 : 4'b0110;
    else if (!s) h = q ? (d ? 4'b0001 : 4'b0100) : 4'b0101;
    else h = q ? (d ? 4'b1000 : 4'b0010) : 4'b1010;
    for (int i = 0; i < 4; i++) g[2*i +: 2] = h[i] ? `GATE_HIGH : `GATE_LOW;
    return g;
  endfunction
  initial begin
    tick(6);
    i_rst_n <= 1'b1;
    tick(4);
    rd(`REG_CTRL, `CTRL_RESET, `RESP_OKAY);
    rd(`REG_BRIDGE_STATUS, 32'h40, `RESP_OKAY);
    rd(8'h20, 32'h0, `RESP_SLVERR);
    wr(`REG_BRIDGE_STATUS, 32'h0, `RESP_SLVERR);
    gates({4{`GATE_RESISTIVE}});
    pwm <= 1'b1;
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    wr(`REG_WATCHDOG, 32'h0, `RESP_OKAY);
    tick(8);
    gates({4{`GATE_LOW}});
    win <= 1'b1;
    wr(`REG_WATCHDOG, 32'h0, `RESP_OKAY);
    win <= 1'b0;
    rd(`REG_WATCHDOG, 32'h0, `RESP_OKAY);
    $display("registers and watchdog done");
    // every direction, pwm and decay combination
    for (int m = 0; m < 16; m++) begin
      wr(`REG_CTRL, {29'h0, m[1], m[0], 1'b1}, `RESP_OKAY);
      dir <= m[2];
      pwm <= m[3];
      tick(8);
      gates(tbl(m[2], m[3], m[0], m[1]));
    end
    ds <= 2'b01;
    tick(8);
    gates({`GATE_LOW, `GATE_LOW, 4'h0} | (tbl(1'b1, 1'b1, 1'b0, 1'b0) & 8'h0F));
    ds <= 2'b00;
    ov <= 1'b1;
    tick(8);
    gates({4{`GATE_LOW}});
    ov <= 1'b0;
    tick(8);
    tsd <= 1'b1;
    tick(8);
    gates({4{`GATE_LOW}});
    ov <= 1'b1;
    tick(4100);
    gates({4{`GATE_RESISTIVE}});
    ov <= 1'b0;
    tsd <= 1'b0;
    $display("bridge table and faults done");
    open <= 4'h1;
    wr(`REG_CTRL, 32'h9, `RESP_OKAY);
    wr(`REG_DRIVE, 32'h1, `RESP_OKAY);
    tick(20);
    check({31'h0, ci}, 32'h0, "blanked");
    tick(30);
    check({31'h0, ci}, 32'h1, "image on");
    check({30'h0, msel}, 32'h0, "select");
    rd(`REG_OPEN_LOAD, 32'h1, `RESP_OKAY);
    check({31'h0, hg[0]}, 32'h1, "still on");
    wr(`REG_CTRL, 32'h109, `RESP_OKAY);
    tick(4);
    check({29'h0, msel, ci}, 32'h2, "select off output");
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    tick(50);
    check({31'h0, ci}, 32'h0, "monitor off");
    open <= 4'h0;
    wr(`REG_DRIVE, 32'h2, `RESP_OKAY);
    check({30'h0, hg[0], lg[0]}, 32'h0, "dead time");
    wait_lg(1'b1, n);
    check({30'h0, fast[0], lg[0]}, 32'h3, "opposite on");
    $display("monitor and dead time done");
    // low side into a short with recovery off: trips and latches
    short <= 4'h1;
    tick(30);
    rd(`REG_OVERCURRENT, 32'h1, `RESP_OKAY);
    short <= 4'h0;
    tick(30);
    check({31'h0, lg[0]}, 32'h0, "latched off");
    wr(`REG_OVERCURRENT, 32'h1, `RESP_OKAY);
    tick(30);
    check({31'h0, lg[0]}, 32'h1, "restart");
    wr(`REG_RECOVERY, 32'h1, `RESP_OKAY);
    short <= 4'h1;
    for (int f = 0; f < 2; f++) begin
      wr(`REG_CTRL, {26'h0, f[1:0], 4'h1}, `RESP_OKAY);
      wait_lg(1'b1, n);
      wait_lg(1'b0, n);
      wait_lg(1'b1, n);
      check({31'h0, n >= (REC << f) - 2 && n <= (REC << f) + 8}, 32'h1, "retry");
    end
    rd(`REG_ALERT, 32'h1, `RESP_OKAY);
    wr(`REG_RECOVERY, 32'h0, `RESP_OKAY);
    wait_lg(1'b0, n);
    repeat (REC * 8) begin
      @(posedge i_clk);
      check({31'h0, lg[0]}, 32'h0, "off after recovery");
    end
    short <= 4'h0;
    $display("overcurrent and recovery done");
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
